// ===== inc/p3p_pkg.sv
// shared constants and types for the port-three interrupt/comparator block
package p3p_pkg;

   // register byte offsets on the bus
   localparam int unsigned ADDR_W = 6;
   localparam logic [5:0] OFS_MODE    = 6'h00; // port_three_mode_reg
   localparam logic [5:0] OFS_CONFIG  = 6'h04; // port_config_reg
   localparam logic [5:0] OFS_DATA    = 6'h08; // output line data
   localparam logic [5:0] OFS_PINS    = 6'h0c; // input lines, comparators
   localparam logic [5:0] OFS_IRQ_ST  = 6'h10; // sticky status, read only
   localparam logic [5:0] OFS_IRQ_CLR = 6'h14; // write one to clear
   localparam logic [5:0] OFS_IRQ_EN  = 6'h18; // interrupt enable
   localparam logic [5:0] OFS_EDGE    = 6'h1c; // edge select lines 1 and 2
   localparam logic [5:0] OFS_CTRL    = 6'h20; // timer / handshake control

   // values after reset
   localparam logic [7:0] RST_MODE   = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'hfe;
   localparam logic [3:0] RST_DATA   = 4'h0;
   localparam logic [3:0] RST_EDGE   = 4'h0;
   localparam logic [3:0] RST_CTRL   = 4'h0;
   localparam logic [3:0] RST_IRQ    = 4'h0;
   localparam logic [3:0] KEEPER_MAP = 4'h1;

   // field positions
   localparam int unsigned MODE_ANALOG  = 1;
   localparam int unsigned CFG_CMP_OUT  = 0;
   localparam int unsigned CFG_P1_PP    = 1;
   localparam int unsigned CFG_P0_PP    = 2;
   localparam int unsigned CFG_EMI_P0   = 3;
   localparam int unsigned CFG_EMI_OSC  = 7;
   localparam int unsigned CTRL_TIMER_OUTPUT_LINE_EN = 0;
   localparam int unsigned CTRL_HS_P0   = 1;
   localparam int unsigned CTRL_HS_P1   = 2;
   localparam int unsigned CTRL_HS_P2   = 3;

   // edge selection for interrupt lines 1 and 2
   typedef enum logic [1:0] {
      P3P_EDGE_FALL = 2'h0,
      P3P_EDGE_RISE = 2'h1,
      P3P_EDGE_BOTH = 2'h2
   } p3p_edge_e;

   // avalon answer phase
   typedef enum logic [0:0] {
      P3P_BUS_WAIT = 1'h0,
      P3P_BUS_ACK  = 1'h1
   } p3p_bus_e;

   // handshake signals coming from ports 0, 1 and 2
   typedef struct packed {
      logic p0_drive;
      logic p1_dav_n;
      logic p2_drive;
   } p3p_hs_in_t;

   // handshake lines returned to ports 0, 1 and 2
   typedef struct packed {
      logic p0_line;
      logic p1_rdy;
      logic p2_line;
   } p3p_hs_out_t;

   // drive settings handed to the pad ring
   typedef struct packed {
      logic       osc_low_emi;
      logic [3:0] port_low_emi;
      logic       p0_push_pull;
      logic       p1_push_pull;
   } p3p_drv_t;

endpackage

// ===== hw/p3p_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module p3p_sync (
   // clock, reset, enable
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       ce_i,
   // async in, synced out
   input  wire logic [5:0] async_i,
   output logic      [5:0] sync_o
);
   import p3p_pkg::*;

   typedef struct packed {
      logic [5:0] meta;
      logic [5:0] stable;
   } p3p_sync_t;

   p3p_sync_t st_r;
   p3p_sync_t st_nxt;

   // first stage is read only by the second stage
   always_comb begin
      st_nxt        = st_r;
      st_nxt.meta   = async_i;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.stable;
endmodule // p3p_sync

// ===== hw/p3p_port.sv
// port-three special-function port with comparators and edge interrupts
//
// Overview of operation
// R1 - four fixed inputs, four fixed outputs
// R2 - analog mode bit enables comparators
// R3 - config bit routes comparators to lines four, seven
// R4 - otherwise ordinary outputs; bit resets zero
// R5 - lines one, two versus reference line three
// R6 - lines zero, three interrupt on falling edge
// R7 - lines one, two: fall, rise or both
// R8 - each edge sets sticky flag until cleared
// R9 - line one timer input, line six output
// R10 - handshake lines of ports zero to two
// R11 - port one: ready line three, valid four
// R12 - port two handshake on lines one, six
// R13 - port zero handshake on lines two, five
// R14 - software waits before reading comparator
// R15 - switch analog mode with interrupts off
// R16 - clear request bits after enabling analog
// R17 - keeper only on input line zero
// R18 - independent low emission drive settings
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module p3p_port (
   // clock, reset, enable
   input  wire logic                 clk_i,
   input  wire logic                 srst_i,
   input  wire logic                 ce_i,
   // avalon-mm slave
   input  wire logic [5:0]           address_i,
   input  wire logic                 read_i,
   input  wire logic                 write_i,
   input  wire logic [3:0]           byteenable_i,
   input  wire logic [31:0]          writedata_i,
   output logic      [31:0]          readdata_o,
   output logic                      waitrequest_o,
   // interrupt
   output logic                      irq_o,
   // pins: input lines 0..3, comparator raw results
   input  wire logic [3:0]           in_line_i,
   input  wire logic [1:0]           cmp_raw_i,
   // pins: output lines 4..7 (bit 0 is line four)
   output logic      [3:0]           out_line_o,
   // timer and handshake partners on the same clock
   input  wire logic                 timer_output_line_i,
   output logic                      timer_input_line_o,
   input  wire p3p_pkg::p3p_hs_in_t  hs_i,
   output p3p_pkg::p3p_hs_out_t      hs_o,
   // pad control
   output logic                      cmp_enable_o,
   output logic      [3:0]           keeper_en_o,
   output p3p_pkg::p3p_drv_t         drv_o
);
   import p3p_pkg::*;

   typedef struct packed {
      p3p_bus_e    bus;
      logic [31:0] rdata;
      logic [7:0]  mode;
      logic [7:0]  cfg;
      logic [3:0]  dout;
      logic [3:0]  edge_sel;
      logic [3:0]  ctrl;
      logic [3:0]  irq_st;
      logic [3:0]  irq_en;
      logic [3:0]  prev;
      logic        irq;
      logic [3:0]  line_out;
      p3p_hs_out_t hs;
      logic        timer_input_line;
      logic        cmp_en;
      logic [3:0]  keep;
      p3p_drv_t    drv;
   } p3p_state_t;

   p3p_state_t st_r;
   p3p_state_t st_nxt;

   logic [5:0] sync;
   logic [3:0] line_in;
   logic [1:0] cmp;
   logic [3:0] cur;
   logic [3:0] evt;
   logic       analog;

   p3p_sync u_sync (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .ce_i    (ce_i),
      .async_i ({cmp_raw_i, in_line_i}),
      .sync_o  (sync)
   );

   assign line_in = sync[3:0];
   assign analog  = st_r.mode[MODE_ANALOG];                    // [R2]
   // comparator results read zero while analog mode is off
   assign cmp     = analog ? sync[5:4] : 2'h0;                 // [R2] [R5]

   // in analog mode lines one and two are seen through the comparators
   assign cur = {line_in[3],
                 analog ? cmp[1] : line_in[2],
                 analog ? cmp[0] : line_in[1],
                 line_in[0]};                                  // [R5]

   // per-line edge detection
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         logic fall;
         logic rise;
         assign fall = st_r.prev[gi] & ~cur[gi];
         assign rise = ~st_r.prev[gi] & cur[gi];
         if (gi == 1 || gi == 2) begin : g_sel
            logic [1:0] sel;
            assign sel = st_r.edge_sel[2*(gi-1) +: 2];
            always_comb begin
               case (sel)
                  P3P_EDGE_FALL: evt[gi] = fall;               // [R7]
                  P3P_EDGE_RISE: evt[gi] = rise;               // [R7]
                  default:       evt[gi] = fall | rise;        // [R7]
               endcase
            end
         end else begin : g_fix
            assign evt[gi] = fall;                             // [R6]
         end
      end
   endgenerate

   // register read mux
   function automatic logic [31:0] rd_mux(input logic [5:0] a,
                                          input p3p_state_t s,
                                          input logic [3:0] pins,
                                          input logic [1:0] c);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         OFS_MODE:    v[7:0] = s.mode;
         OFS_CONFIG:  v[7:0] = s.cfg;
         OFS_DATA:    v[3:0] = s.dout;
         OFS_PINS:    v[5:0] = {c, pins};
         OFS_IRQ_ST:  v[3:0] = s.irq_st;
         OFS_IRQ_EN:  v[3:0] = s.irq_en;
         OFS_EDGE:    v[3:0] = s.edge_sel;
         OFS_CTRL:    v[3:0] = s.ctrl;
         default:     v      = 32'h0;
      endcase
      return v;
   endfunction

   always_comb begin
      logic       wr_go;
      logic [3:0] clr;
      logic [3:0] d;
      logic [7:0] wb;
      wr_go  = 1'b0;
      clr    = 4'h0;
      d      = 4'h0;
      wb     = writedata_i[7:0];
      st_nxt = st_r;

      // bus: one wait cycle, then the answer edge
      case (st_r.bus)
         P3P_BUS_WAIT: begin
            if (read_i || write_i) begin
               st_nxt.bus   = P3P_BUS_ACK;
               st_nxt.rdata = read_i ? rd_mux(address_i, st_r, line_in, cmp)
                                     : 32'h0;
            end
         end
         P3P_BUS_ACK: begin
            st_nxt.bus = P3P_BUS_WAIT;
            wr_go      = write_i && byteenable_i[0];
         end
         default: st_nxt.bus = P3P_BUS_WAIT;
      endcase

      // writes land at the edge where waitrequest is seen low
      if (wr_go) begin
         case (address_i)
            OFS_MODE:    st_nxt.mode     = wb;                 // [R2]
            OFS_CONFIG:  st_nxt.cfg      = wb;                 // [R3] [R18]
            OFS_DATA:    st_nxt.dout     = wb[3:0];
            OFS_IRQ_CLR: clr             = wb[3:0];
            OFS_IRQ_EN:  st_nxt.irq_en   = wb[3:0];
            OFS_EDGE:    st_nxt.edge_sel = wb[3:0];            // [R7]
            OFS_CTRL:    st_nxt.ctrl     = wb[3:0];            // [R10]
            default:     clr             = 4'h0;
         endcase
      end

      // sticky flags: a new edge wins over a clear in the same cycle
      st_nxt.prev   = cur;
      st_nxt.irq_st = (st_r.irq_st & ~clr) | evt;              // [R8] [R6]
      st_nxt.irq    = |(st_nxt.irq_st & st_nxt.irq_en);

      // output lines: fixed direction, data unless a function claims them
      d = st_nxt.dout;                                         // [R1] [R4]
      if (st_nxt.ctrl[CTRL_HS_P1]) begin
         d[0] = hs_i.p1_dav_n;                                 // [R11]
      end
      if (st_nxt.ctrl[CTRL_HS_P0]) begin
         // ready or valid meaning follows port zero's upper nibble
         d[1] = hs_i.p0_drive;                                 // [R13]
      end
      if (st_nxt.ctrl[CTRL_TIMER_OUTPUT_LINE_EN]) begin
         d[2] = timer_output_line_i;                           // [R9]
      end else if (st_nxt.ctrl[CTRL_HS_P2]) begin
         // meaning follows port two bit 7 direction
         d[2] = hs_i.p2_drive;                                 // [R12]
      end
      // comparator routing has priority over every other use
      if (st_nxt.cfg[CFG_CMP_OUT]) begin
         d[0] = cmp[0];                                        // [R3]
         d[3] = cmp[1];                                        // [R3]
      end
      st_nxt.line_out = d;

      // inputs returned to timer and handshake partners
      st_nxt.timer_input_line        = line_in[1];                          // [R9]
      st_nxt.hs.p0_line = line_in[2];                          // [R13]
      st_nxt.hs.p1_rdy  = line_in[3];                          // [R11]
      st_nxt.hs.p2_line = line_in[1];                          // [R12] [R10]

      // pad controls; lines one to three stay without keepers
      st_nxt.cmp_en = st_nxt.mode[MODE_ANALOG];                // [R2]
      st_nxt.keep   = KEEPER_MAP;                              // [R17]
      st_nxt.drv.osc_low_emi  = ~st_nxt.cfg[CFG_EMI_OSC];      // [R18]
      st_nxt.drv.port_low_emi = ~st_nxt.cfg[CFG_EMI_P0 +: 4];  // [R18]
      st_nxt.drv.p0_push_pull = st_nxt.cfg[CFG_P0_PP];
      st_nxt.drv.p1_push_pull = st_nxt.cfg[CFG_P1_PP];
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r          <= '0;
         st_r.mode     <= RST_MODE;
         st_r.cfg      <= RST_CONFIG;                          // [R4]
         st_r.dout     <= RST_DATA;
         st_r.edge_sel <= RST_EDGE;
         st_r.ctrl     <= RST_CTRL;
         st_r.irq_st   <= RST_IRQ;
         st_r.irq_en   <= RST_IRQ;
         st_r.keep     <= KEEPER_MAP;
         st_r.drv      <= '{osc_low_emi: 1'b0, port_low_emi: 4'h0,
                            p0_push_pull: 1'b1, p1_push_pull: 1'b1};
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   // every output but waitrequest is a flip-flop of the state; waitrequest decodes the bus phase
   assign readdata_o         = st_r.rdata;
   assign waitrequest_o      = (st_r.bus == P3P_BUS_WAIT);
   assign irq_o              = st_r.irq;
   assign out_line_o         = st_r.line_out;
   assign timer_input_line_o = st_r.timer_input_line;
   assign hs_o               = st_r.hs;
   assign cmp_enable_o       = st_r.cmp_en;
   assign keeper_en_o        = st_r.keep;
   assign drv_o              = st_r.drv;
endmodule // p3p_port

// ===== verification/p3p_partner.sv
// far-side pin model: analog sources, timer and handshake ports
`timescale 1ns/1ps
module p3p_partner
   import p3p_pkg::*;
#(
   parameter int TRIP_MV = 2500
)(
   // clock
   input  wire logic               clk_i,
   // commanded levels, millivolts on lines one to three
   input  wire logic               line0_i,
   input  wire logic signed [31:0] mv1_i,
   input  wire logic signed [31:0] mv2_i,
   input  wire logic signed [31:0] mv3_i,
   input  wire logic        [3:0]  misc_i,
   // pins seen by the port
   output logic             [3:0]  in_line_o,
   output logic             [1:0]  cmp_raw_o,
   output logic                    timer_output_line_o,
   output p3p_hs_in_t              hs_o
);
   // pins move just after the edge, as a clocked source would
   always_ff @(posedge clk_i) begin
      in_line_o <= {mv3_i > TRIP_MV, mv2_i > TRIP_MV,
                    mv1_i > TRIP_MV, line0_i};
      cmp_raw_o <= {mv2_i > mv3_i, mv1_i > mv3_i};
      timer_output_line_o    <= misc_i[0];
      hs_o      <= misc_i[3:1];
   end
endmodule // p3p_partner

// ===== verification/p3p_asserts.sv
// concurrent checks on the port-three block pins
`timescale 1ns/1ps
module p3p_asserts
   import p3p_pkg::*;
(
   // watched ports
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic        ce_i,
   input wire logic [5:0]  address_i,
   input wire logic        write_i,
   input wire logic [3:0]  byteenable_i,
   input wire logic [31:0] writedata_i,
   input wire logic        waitrequest_o,
   input wire logic        irq_o,
   input wire logic [3:0]  in_line_i,
   input wire logic [1:0]  cmp_raw_i,
   input wire logic [3:0]  out_line_o,
   input wire logic        timer_output_line_i,
   input wire logic        timer_input_line_o,
   input wire p3p_hs_in_t  hs_i,
   input wire p3p_hs_out_t hs_o,
   input wire logic        cmp_enable_o,
   input wire logic [3:0]  keeper_en_o,
   input wire p3p_drv_t    drv_o
);
   logic       wt;
   logic [7:0] cfg_r;
   logic [7:0] mode_r;
   logic [3:0] ctrl_r;
   default clocking @(posedge clk_i); endclocking
   // a low enable freezes the block, so nothing is expected to move then
   default disable iff (srst_i || !ce_i);
   // shadow copies, since config is not visible at the pins
   assign wt = ce_i && write_i && !waitrequest_o && byteenable_i[0];
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cfg_r  <= RST_CONFIG;
         mode_r <= RST_MODE;
         ctrl_r <= RST_CTRL;
      end else if (wt) begin
         if (address_i == OFS_CONFIG) cfg_r <= writedata_i[7:0];
         if (address_i == OFS_MODE) mode_r <= writedata_i[7:0];
         if (address_i == OFS_CTRL) ctrl_r <= writedata_i[3:0];
      end
   end
   sequence s_cmp_hold;
      (cfg_r[0] && cmp_enable_o && $stable(cmp_raw_i)) [*5];
   endsequence
   // margin of two edges over the three-edge sync path
   property p_follow(logic a, logic b);
      $stable(a) [*5] |-> b == a;
   endproperty
   property p_drive(logic en, logic a, logic b);
      (en && !cfg_r[0] && $stable(a)) [*3] |-> b == a;
   endproperty
   a_cmp_enable: assert property (
      wt && address_i == OFS_MODE |-> ##[1:2] cmp_enable_o == mode_r[1])
      else $error("analog enable mismatch");
   a_cmp_route: assert property (
      s_cmp_hold |-> out_line_o[0] == cmp_raw_i[0]
      && out_line_o[3] == cmp_raw_i[1]) else $error("comparator route");
   a_data_out: assert property (
      wt && address_i == OFS_DATA && !cfg_r[0] && ctrl_r == 4'h0
      |=> out_line_o == $past(writedata_i[3:0])) else $error("data out");
   a_line_keeper: assert property (
      keeper_en_o == KEEPER_MAP) else $error("keeper map");
   a_timer_in: assert property (
      p_follow(in_line_i[1], timer_input_line_o)) else $error("timer in");
   a_ready_line: assert property (
      p_follow(in_line_i[3], hs_o.p1_rdy)) else $error("ready line");
   a_timer_out: assert property (
      p_drive(ctrl_r[0], timer_output_line_i, out_line_o[2]))
      else $error("timer out");
   a_valid_line: assert property (
      p_drive(ctrl_r[2], hs_i.p1_dav_n, out_line_o[0]))
      else $error("valid line");
   a_irq_off: assert property (
      wt && address_i == OFS_IRQ_EN && writedata_i[3:0] == 4'h0 |=> !irq_o)
      else $error("irq not masked");
   a_emi_drive: assert property (
      wt && address_i == OFS_CONFIG |-> ##[1:2]
      drv_o == {~cfg_r[7], ~cfg_r[6:3], cfg_r[2:1]}) else $error("drive");
endmodule // p3p_asserts

// ===== verification/tb_top.sv
// self-checking bench for the port-three block
`timescale 1ns/1ps
module tb_top;
   import p3p_pkg::*;
   logic        clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        read_i = 1'b0;
   logic        write_i = 1'b0;
   logic [5:0]  address_i = 6'h00;
   logic [31:0] writedata_i = 32'h0;
   logic [31:0] readdata_o, q;
   logic        waitrequest_o, irq_o, timer_input_line_o, cmp_enable_o;
   logic        timer_output_line, line0 = 1'b0, ce = 1'b1;
   logic [3:0]  in_line, out_line_o, keeper_en_o, misc = 4'h0;
   logic [3:0]  hv;
   logic [1:0]  cmp_raw;
   int          mv1 = 0, mv2 = 0, mv3 = 0, fail_count = 0, checked = 0;
   p3p_hs_in_t  hs_in;
   p3p_hs_out_t hs_o;
   p3p_drv_t    drv_o;
   logic [5:0]  offs [10] = '{OFS_MODE, OFS_CONFIG, OFS_DATA, OFS_PINS,
      OFS_IRQ_ST, OFS_IRQ_CLR, OFS_IRQ_EN, OFS_EDGE, OFS_CTRL, 6'h3c};
   logic [3:0]  hs_tab [3] = '{4'h4, 4'hc, 4'h2};
   always #50 clk_i = ~clk_i;
   // byte lane is held on: only lane 0 is decoded
   p3p_port p3p_port_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce),
      .address_i(address_i), .read_i(read_i), .write_i(write_i),
      .byteenable_i(4'h1), .writedata_i(writedata_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .irq_o(irq_o), .in_line_i(in_line), .cmp_raw_i(cmp_raw),
      .out_line_o(out_line_o), .timer_output_line_i(timer_output_line),
      .timer_input_line_o(timer_input_line_o), .hs_i(hs_in), .hs_o(hs_o),
      .cmp_enable_o(cmp_enable_o), .keeper_en_o(keeper_en_o),
      .drv_o(drv_o));
   p3p_partner p3p_partner_inst (.clk_i(clk_i), .line0_i(line0),
      .mv1_i(mv1), .mv2_i(mv2), .mv3_i(mv3), .misc_i(misc),
      .in_line_o(in_line), .cmp_raw_o(cmp_raw), .timer_output_line_o(timer_output_line),
      .hs_o(hs_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (fail_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      address_i   <= a;
      writedata_i <= d;
      write_i     <= wr;
      read_i      <= !wr;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 40);
      q = readdata_o;
      if (waitrequest_o !== 1'b0) begin
         fail_count++;
         give_verdict();
      end
      write_i <= 1'b0;
      read_i  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   task automatic lines(input logic v);
      line0 <= v;
      mv1   <= v ? 3300 : 0;
      mv2   <= v ? 3300 : 0;
      mv3   <= v ? 3300 : 0;
      repeat (6) @(posedge clk_i);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      foreach (offs[i]) begin
         rd(offs[i], (offs[i] == OFS_CONFIG) ? 32'hfe : 0);
      end
      check(keeper_en_o, KEEPER_MAP);
      check(drv_o, 7'h03);
      wr(OFS_DATA, 32'h6);
      check(out_line_o, 4'h6);
      wr(6'h3c, 32'h9);
      rd(OFS_DATA, 32'h6);
      line0 <= 1'b1;
      mv1   <= 3300;
      repeat (6) @(posedge clk_i);
      rd(OFS_PINS, 32'h3);
      check(timer_input_line_o, 1'b1);
      check(irq_o, 1'b0);
      wr(OFS_MODE, 32'h2);
      mv2 <= 1000;
      mv3 <= 2000;
      repeat (6) @(posedge clk_i);
      wr(OFS_IRQ_CLR, 32'hf);
      check(cmp_enable_o, 1'b1);
      bus(1'b0, OFS_PINS, 32'h0);
      check(q[5:4], 2'h1);
      wr(OFS_CONFIG, 32'hff);
      repeat (6) @(posedge clk_i);
      check(out_line_o, 4'h7);
      mv1 <= 1000;
      mv2 <= 3300;
      repeat (6) @(posedge clk_i);
      check(out_line_o, 4'he);
      wr(OFS_CONFIG, 32'hfe);
      check(out_line_o, 4'h6);
      wr(OFS_MODE, 32'h0);
      lines(1'b0);
      check(cmp_enable_o, 1'b0);
      wr(OFS_IRQ_CLR, 32'hf);
      for (int m = 0; m < 3; m++) begin
         wr(OFS_IRQ_CLR, 32'hf);
         wr(OFS_EDGE, {28'h0, m[1:0], m[1:0]});
         lines(1'b1);
         rd(OFS_IRQ_ST, (m != 0) ? 32'h6 : 32'h0);
         wr(OFS_IRQ_CLR, 32'hf);
         lines(1'b0);
         rd(OFS_IRQ_ST, (m != 1) ? 32'hf : 32'h9);
      end
      rd(OFS_IRQ_ST, 32'hf);
      wr(OFS_IRQ_EN, 32'h9);
      check(irq_o, 1'b1);
      wr(OFS_IRQ_CLR, 32'h9);
      check(irq_o, 1'b0);
      rd(OFS_IRQ_ST, 32'h6);
      wr(OFS_IRQ_EN, 32'h2);
      check(irq_o, 1'b1);
      wr(OFS_IRQ_EN, 32'h0);
      check(irq_o, 1'b0);
      wr(OFS_CTRL, 32'h1);
      misc <= 4'h1;
      repeat (4) @(posedge clk_i);
      check(out_line_o, 4'h6);
      misc <= 4'h0;
      repeat (4) @(posedge clk_i);
      check(out_line_o, 4'h2);
      wr(OFS_CTRL, 32'he);
      foreach (hs_tab[i]) begin
         hv = hs_tab[i];
         misc <= hs_tab[i];
         mv1  <= hs_tab[i][1] ? 3300 : 0;
         mv2  <= hs_tab[i][3] ? 3300 : 0;
         mv3  <= hs_tab[i][2] ? 3300 : 0;
         repeat (6) @(posedge clk_i);
         check(out_line_o, {1'b0, hv[1], hv[3:2]});
         check(hs_o, hs_tab[i][3:1]);
      end
      wr(OFS_CONFIG, 32'h54);
      repeat (2) @(posedge clk_i);
      check(drv_o, 7'h56);
      // a low enable must hold the lines while the partner moves
      ce   <= 1'b0;
      misc <= 4'h4;
      repeat (4) @(posedge clk_i);
      check(out_line_o, 4'h4);
      ce <= 1'b1;
      repeat (4) @(posedge clk_i);
      check(out_line_o, 4'h1);
      give_verdict();
   end
endmodule // tb_top
bind p3p_port p3p_asserts p3p_asserts_inst (.clk_i(clk_i), .srst_i(srst_i),
   .ce_i(ce_i), .address_i(address_i), .write_i(write_i),
   .byteenable_i(byteenable_i), .writedata_i(writedata_i),
   .waitrequest_o(waitrequest_o), .irq_o(irq_o), .in_line_i(in_line_i),
   .cmp_raw_i(cmp_raw_i), .out_line_o(out_line_o),
   .timer_output_line_i(timer_output_line_i),
   .timer_input_line_o(timer_input_line_o), .hs_i(hs_i), .hs_o(hs_o),
   .cmp_enable_o(cmp_enable_o), .keeper_en_o(keeper_en_o), .drv_o(drv_o));
